// ===== include/tsn_map.vh
/*
 Constants of the touch switch notifier.
 Assumes a 200 MHz clock and byte addresses.
*/
`ifndef TSN_MAP_VH
`define TSN_MAP_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define TSN_CLK_KHZ 200000
`define TSN_BLINK_HALF_MS 500
`define TSN_STROBE_HOLD_US 1

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define TSN_REG_CTRL 8'h00
`define TSN_REG_STAT 8'h04
`define TSN_REG_MASK 8'h08
`define TSN_REG_NSTATE 8'h0c
`define TSN_REG_SAREA 8'h10
`define TSN_REGION_CFG 2'h1
`define TSN_REGION_SNAP 2'h2

// ----------------------------------------------------------------------
// Control and status bits
// ----------------------------------------------------------------------
`define TSN_CTRL_PEER 0
`define TSN_CTRL_EN 1
`define TSN_CTRL_RST 2'h0
`define TSN_ST_SW 0
`define TSN_ST_NUM 1
`define TSN_ST_GONE 2

// ----------------------------------------------------------------------
// Per switch configuration word
// ----------------------------------------------------------------------
`define TSN_CFG_TYPE_LSB 0
`define TSN_CFG_BLINK 2
`define TSN_CFG_DMEM 3
`define TSN_CFG_BIT_LSB 4
`define TSN_CFG_WADDR_LSB 8
`define TSN_TYPE_MOM 2'h0
`define TSN_TYPE_ALT 2'h1
`define TSN_TYPE_SET 2'h2
`define TSN_TYPE_RST 2'h3

// ----------------------------------------------------------------------
// Status notify area layout
// ----------------------------------------------------------------------
`define TSN_SA_STROBE_OFS 16'h0000
`define TSN_SA_ENTRY_OFS 16'h0001
`define TSN_STROBE_BIT 4'h3
`define TSN_WORD_ALL 16'hffff
`define TSN_WORD_NONE 16'h0000
`define TSN_BIT_ONE 16'h0001

`endif

// ===== rtl/tsn_snap_mem.v
/*
 Snapshot memory: one display-time word per switch.
 Assumes one clock; registered read data.
*/
`timescale 1ns/1ps
module tsn_snap_mem #(
   parameter DEPTH = 16,
   parameter AW = 4,
   parameter DW = 16
) (
   clk,
   we,
   waddr,
   wdata,
   raddr,
   rdata
);
   input wire clk;
   input wire we;
   input wire [AW-1:0] waddr;
   input wire [DW-1:0] wdata;
   input wire [AW-1:0] raddr;
   output reg [DW-1:0] rdata;

   reg [DW-1:0] mem_q [0:DEPTH-1];

   // Write port and registered read port
   always @(posedge clk)
   begin
      if (we)
      begin
         mem_q[waddr] <= wdata;
      end
      rdata <= mem_q[raddr];
   end
endmodule // tsn_snap_mem

// ===== rtl/tsn_top.v
/*
 Touch switch notifier: lamps, switch notices, numeral entry notices.
 Assumes a write port acked by mem_wr_ack, inputs synchronous to clk.
*/
// Decided for this implementation: the Avalon-MM register port and the address map.
//
// Function
// - Lamp shows unlit for control bit 0, lit or flashing for bit 1.
// - Per switch attribute picks steady or blinking light.
// - A press updates the switch notify bit in controller memory unaided.
// - Momentary: bit follows press; alternate: each press inverts the bit.
// - Set type: press drives bit to 1, stays after release.
// - Reset type: press drives bit to 0, stays after release.
// - Momentary in word mode writes whole word, other bits cleared.
// - Other types in word mode write word built from display-time snapshot.
// - Peer link outside data memory: single bit write, other bits kept.
// - Screen change while momentary held notifies off; word mode clears word.
// - Numeral entry sets the strobe flag in the status notify area.
// - Updated table entry number is written to the status entry word.
// - Entry word holds number 000 to 999 as three BCD digits.
// - Strobe flag returns to 0 after being delivered.
`timescale 1ns/1ps
`include "tsn_map.vh"
module tsn_top #(
   parameter NSW = 16,
   parameter SWW = 4,
   parameter BLINK_HALF = `TSN_BLINK_HALF_MS * `TSN_CLK_KHZ,
   parameter STROBE_HOLD = (`TSN_STROBE_HOLD_US * `TSN_CLK_KHZ + 999) / 1000
) (
   clk,
   nrst,
   avs_address,
   avs_read,
   avs_write,
   avs_writedata,
   avs_readdata,
   avs_waitrequest,
   irq,
   sw_press,
   screen_change,
   num_entry,
   num_entry_idx,
   lamp_bits,
   lamp_out,
   mem_wr_req,
   mem_wr_addr,
   mem_wr_data,
   mem_wr_mask,
   mem_wr_ack
);
   input wire clk;
   input wire nrst;
   input wire [7:0] avs_address;
   input wire avs_read;
   input wire avs_write;
   input wire [31:0] avs_writedata;
   output reg [31:0] avs_readdata;
   output wire avs_waitrequest;
   output wire irq;
   input wire [NSW-1:0] sw_press;
   input wire screen_change;
   input wire num_entry;
   input wire [9:0] num_entry_idx;
   input wire [NSW-1:0] lamp_bits;
   output reg [NSW-1:0] lamp_out;
   output reg mem_wr_req;
   output reg [15:0] mem_wr_addr;
   output reg [15:0] mem_wr_data;
   output reg [15:0] mem_wr_mask;
   input wire mem_wr_ack;

   localparam S_IDLE = 3'h0;
   localparam S_SW_RD = 3'h1;
   localparam S_SW_WR = 3'h2;
   localparam S_NUM_ENT = 3'h3;
   localparam S_NUM_SET = 3'h4;
   localparam S_NUM_HOLD = 3'h5;
   localparam S_NUM_CLR = 3'h6;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   reg [1:0] ctrl_q;
   reg [2:0] stat_q;
   reg [2:0] mask_q;
   reg [15:0] sarea_q;
   reg [23:0] cfg_q [0:NSW-1];
   reg [NSW-1:0] sw_prev_q;
   reg [NSW-1:0] pend_q;
   reg [NSW-1:0] gone_q;
   reg [NSW-1:0] cur_q;
   reg [2:0] state_q;
   reg [SWW-1:0] sel_q;
   reg sel_val_q;
   reg num_pend_q;
   reg [11:0] entry_q;
   reg [31:0] hold_q;
   reg [31:0] blink_cnt_q;
   reg blink_ph_q;
   reg rd_ok_q;
   reg [NSW-1:0] pend_set;
   reg [NSW-1:0] pend_clr;
   reg [NSW-1:0] gone_set;
   reg pick_any;
   reg [SWW-1:0] pick_idx;
   reg pick_val;
   reg [2:0] st_set;
   integer k;
   wire en = ctrl_q[`TSN_CTRL_EN];
   wire peer = ctrl_q[`TSN_CTRL_PEER];
   wire [1:0] region = avs_address[7:6];
   wire [SWW-1:0] avs_idx = avs_address[SWW+1:2];
   wire snap_sel = (region == `TSN_REGION_SNAP);
   wire fsm_mem = (state_q == S_IDLE) && pick_any && !num_pend_q;
   wire [15:0] snap_rdata;
   wire [23:0] sel_cfg = cfg_q[sel_q];
   wire [1:0] sel_type = sel_cfg[`TSN_CFG_TYPE_LSB+1:`TSN_CFG_TYPE_LSB];
   wire [3:0] sel_bit = sel_cfg[`TSN_CFG_BIT_LSB+3:`TSN_CFG_BIT_LSB];
   wire [15:0] sel_m = `TSN_BIT_ONE << sel_bit;
   wire sel_word = !peer || sel_cfg[`TSN_CFG_DMEM];
   wire [15:0] strobe_m = `TSN_BIT_ONE << `TSN_STROBE_BIT;

   // Binary to three BCD digits by shift and add
   function [11:0] to_bcd;
      input [9:0] bin;
      reg [21:0] sh;
      integer i;
      begin
         sh = {12'h000, bin};
         for (i = 0; i < 10; i = i + 1)
         begin
            if (sh[13:10] > 4'h4)
               sh[13:10] = sh[13:10] + 4'h3;
            if (sh[17:14] > 4'h4)
               sh[17:14] = sh[17:14] + 4'h3;
            if (sh[21:18] > 4'h4)
               sh[21:18] = sh[21:18] + 4'h3;
            sh = {sh[20:0], 1'b0};
         end
         to_bcd = sh[21:10];
      end
   endfunction

   // ----------------------------------------------------------------------
   // Snapshot memory
   // ----------------------------------------------------------------------
   tsn_snap_mem #(
      .DEPTH(NSW),
      .AW(SWW),
      .DW(16)
   ) u_snap (
      .clk(clk),
      .we(avs_write && snap_sel),
      .waddr(avs_idx),
      .wdata(avs_writedata[15:0]),
      .raddr(fsm_mem ? pick_idx : avs_idx),
      .rdata(snap_rdata)
   );

   // ----------------------------------------------------------------------
   // Switch event capture
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NSW; g = g + 1)
      begin : g_sw
         wire [1:0] typ = cfg_q[g][`TSN_CFG_TYPE_LSB+1:`TSN_CFG_TYPE_LSB];
         wire mom = (typ == `TSN_TYPE_MOM);
         wire press_ev = sw_press[g] && !sw_prev_q[g];
         wire rel_ev = !sw_press[g] && sw_prev_q[g];
         wire lamp_lit = lamp_bits[g] && (!cfg_q[g][`TSN_CFG_BLINK] || blink_ph_q);

         // Pending notice per switch, set beats clear
         always @*
         begin
            gone_set[g] = screen_change && sw_press[g] && mom;
            pend_set[g] = en && (press_ev || gone_set[g] || (mom && rel_ev && !gone_q[g]));
         end

         // Edge memory, held-across-screen flag, pending flag and lamp
         always @(posedge clk)
         begin
            if (!nrst)
            begin
               sw_prev_q[g] <= 1'b0;
               gone_q[g] <= 1'b0;
               pend_q[g] <= 1'b0;
               lamp_out[g] <= 1'b0;
               cfg_q[g] <= 24'h000000;
            end
            else
            begin
               sw_prev_q[g] <= sw_press[g];
               if (gone_set[g])
                  gone_q[g] <= 1'b1;
               else if (rel_ev)
                  gone_q[g] <= 1'b0;
               pend_q[g] <= (pend_q[g] && !pend_clr[g]) || pend_set[g];
               lamp_out[g] <= lamp_lit;
               if (avs_write && region == `TSN_REGION_CFG && avs_idx == g)
                  cfg_q[g] <= avs_writedata[23:0];
            end
         end
      end
   endgenerate

   // Lowest pending switch and its new notify value
   always @*
   begin
      pick_any = 1'b0;
      pick_idx = {SWW{1'b0}};
      for (k = NSW - 1; k >= 0; k = k - 1)
      begin
         if (pend_q[k])
         begin
            pick_any = 1'b1;
            pick_idx = k[SWW-1:0];
         end
      end
      case (cfg_q[pick_idx][`TSN_CFG_TYPE_LSB+1:`TSN_CFG_TYPE_LSB])
         `TSN_TYPE_MOM: pick_val = sw_press[pick_idx] && !gone_q[pick_idx] && !screen_change;
         `TSN_TYPE_ALT: pick_val = !cur_q[pick_idx];
         `TSN_TYPE_SET: pick_val = 1'b1;
         default: pick_val = 1'b0;
      endcase
      pend_clr = {NSW{1'b0}};
      if (fsm_mem)
         pend_clr[pick_idx] = 1'b1;
   end

   // ----------------------------------------------------------------------
   // Notification sequencer
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         state_q <= S_IDLE;
         sel_q <= {SWW{1'b0}};
         sel_val_q <= 1'b0;
         cur_q <= {NSW{1'b0}};
         num_pend_q <= 1'b0;
         entry_q <= 12'h000;
         hold_q <= 32'h00000000;
         mem_wr_req <= 1'b0;
         mem_wr_addr <= 16'h0000;
         mem_wr_data <= 16'h0000;
         mem_wr_mask <= 16'h0000;
      end
      else
      begin
         if (en && num_entry)
         begin
            num_pend_q <= 1'b1;
            entry_q <= to_bcd(num_entry_idx);
         end
         case (state_q)
            S_IDLE:
            begin
               if (num_pend_q)
               begin
                  if (!(en && num_entry))
                     num_pend_q <= 1'b0;
                  mem_wr_req <= 1'b1;
                  mem_wr_addr <= sarea_q + `TSN_SA_ENTRY_OFS;
                  mem_wr_data <= {4'h0, entry_q};
                  mem_wr_mask <= `TSN_WORD_ALL;
                  state_q <= S_NUM_ENT;
               end
               else if (pick_any)
               begin
                  sel_q <= pick_idx;
                  sel_val_q <= pick_val;
                  cur_q[pick_idx] <= pick_val;
                  state_q <= S_SW_RD;
               end
            end
            S_SW_RD:
            begin
               mem_wr_req <= 1'b1;
               mem_wr_addr <= sel_cfg[`TSN_CFG_WADDR_LSB+15:`TSN_CFG_WADDR_LSB];
               if (!sel_word)
               begin
                  mem_wr_data <= sel_val_q ? sel_m : `TSN_WORD_NONE;
                  mem_wr_mask <= sel_m;
               end
               else if (sel_type == `TSN_TYPE_MOM)
               begin
                  mem_wr_data <= sel_val_q ? sel_m : `TSN_WORD_NONE;
                  mem_wr_mask <= `TSN_WORD_ALL;
               end
               else
               begin
                  mem_wr_data <= sel_val_q ? (snap_rdata | sel_m) : (snap_rdata & ~sel_m);
                  mem_wr_mask <= `TSN_WORD_ALL;
               end
               state_q <= S_SW_WR;
            end
            S_SW_WR:
            begin
               if (mem_wr_ack)
               begin
                  mem_wr_req <= 1'b0;
                  state_q <= S_IDLE;
               end
            end
            S_NUM_ENT:
            begin
               if (mem_wr_ack)
               begin
                  mem_wr_req <= 1'b0;
                  mem_wr_addr <= sarea_q + `TSN_SA_STROBE_OFS;
                  mem_wr_data <= strobe_m;
                  mem_wr_mask <= strobe_m;
                  state_q <= S_NUM_SET;
               end
            end
            S_NUM_SET:
            begin
               if (mem_wr_ack)
               begin
                  mem_wr_req <= 1'b0;
                  hold_q <= 32'h00000000;
                  state_q <= S_NUM_HOLD;
               end
               else
                  mem_wr_req <= 1'b1;
            end
            S_NUM_HOLD:
            begin
               // Hold the flag so the controller sees its edge
               hold_q <= hold_q + 32'h00000001;
               if (hold_q >= STROBE_HOLD - 1)
               begin
                  mem_wr_req <= 1'b1;
                  mem_wr_data <= `TSN_WORD_NONE;
                  state_q <= S_NUM_CLR;
               end
            end
            S_NUM_CLR:
            begin
               if (mem_wr_ack)
               begin
                  mem_wr_req <= 1'b0;
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Blink divider
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         blink_cnt_q <= 32'h00000000;
         blink_ph_q <= 1'b0;
      end
      else if (blink_cnt_q >= BLINK_HALF - 1)
      begin
         blink_cnt_q <= 32'h00000000;
         blink_ph_q <= !blink_ph_q;
      end
      else
         blink_cnt_q <= blink_cnt_q + 32'h00000001;
   end

   // ----------------------------------------------------------------------
   // Register bus and interrupt
   // ----------------------------------------------------------------------
   assign avs_waitrequest = avs_read && !rd_ok_q;
   assign irq = |(stat_q & mask_q);

   // Interrupt events from completed writes and forced off notices
   always @*
   begin
      st_set = 3'h0;
      st_set[`TSN_ST_SW] = (state_q == S_SW_WR) && mem_wr_ack;
      st_set[`TSN_ST_NUM] = (state_q == S_NUM_SET) && mem_wr_ack;
      st_set[`TSN_ST_GONE] = |gone_set;
   end

   // Register writes, sticky status, read data capture
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         ctrl_q <= `TSN_CTRL_RST;
         stat_q <= 3'h0;
         mask_q <= 3'h0;
         sarea_q <= 16'h0000;
         rd_ok_q <= 1'b0;
         avs_readdata <= 32'h00000000;
      end
      else
      begin
         if (avs_write && avs_address == `TSN_REG_STAT)
            stat_q <= (stat_q & ~avs_writedata[2:0]) | st_set;
         else
            stat_q <= stat_q | st_set;
         if (avs_write && avs_address == `TSN_REG_CTRL)
            ctrl_q <= avs_writedata[1:0];
         if (avs_write && avs_address == `TSN_REG_MASK)
            mask_q <= avs_writedata[2:0];
         if (avs_write && avs_address == `TSN_REG_SAREA)
            sarea_q <= avs_writedata[15:0];
         rd_ok_q <= avs_read && !rd_ok_q && !(snap_sel && fsm_mem);
         if (avs_read && !rd_ok_q)
         begin
            case (avs_address)
               `TSN_REG_CTRL: avs_readdata <= {30'h00000000, ctrl_q};
               `TSN_REG_STAT: avs_readdata <= {29'h00000000, stat_q};
               `TSN_REG_MASK: avs_readdata <= {29'h00000000, mask_q};
               `TSN_REG_NSTATE: avs_readdata <= {{(32-NSW){1'b0}}, cur_q};
               `TSN_REG_SAREA: avs_readdata <= {16'h0000, sarea_q};
               default:
               begin
                  if (region == `TSN_REGION_CFG)
                     avs_readdata <= {8'h00, cfg_q[avs_idx]};
                  else
                     avs_readdata <= 32'h00000000;
               end
            endcase
         end
         else if (rd_ok_q && snap_sel)
            avs_readdata <= 32'h00000000;
      end
   end
endmodule // tsn_top

// ===== tb/tsn_top_chk.sv
/*
 Port checker of the notifier.
 Assumes a bind onto tsn_top.
*/
`timescale 1ns/1ps
module tsn_chk #(
   parameter NSW = 16
) (
   input clk,
   input nrst,
   input [7:0] avs_address,
   input avs_read,
   input avs_write,
   input [31:0] avs_writedata,
   input avs_waitrequest,
   input [NSW-1:0] sw_press,
   input num_entry,
   input [NSW-1:0] lamp_bits,
   input [NSW-1:0] lamp_out,
   input mem_wr_req,
   input [15:0] mem_wr_addr,
   input [15:0] mem_wr_data,
   input [15:0] mem_wr_mask,
   input mem_wr_ack
);
   reg en_q;
   // ------------------------------------------------------------
   // Enable shadow and timing defaults
   // ------------------------------------------------------------
   // Enable bit shadow
   always @(posedge clk)
   begin
      if (!nrst)
         en_q <= 1'h0;
      else if (avs_write && avs_address == 8'h00)
         en_q <= avs_writedata[1];
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Strobe set accepted, then strobe cleared
   sequence strobe_on_s;
      mem_wr_req && mem_wr_ack && mem_wr_mask == 16'h0008 && mem_wr_data[3];
   endsequence
   sequence strobe_off_s;
      mem_wr_req && mem_wr_mask == 16'h0008 && !mem_wr_data[3];
   endsequence
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   wr_hold_a: assert property (mem_wr_req && !mem_wr_ack |=> mem_wr_req
      && $stable(mem_wr_addr) && $stable(mem_wr_data) && $stable(mem_wr_mask))
      else $error("write changed before ack");
   req_drop_a: assert property (mem_wr_req && mem_wr_ack |=> !mem_wr_req)
      else $error("request held after ack");
   mask_form_a: assert property (mem_wr_req |->
      mem_wr_mask == 16'hffff || $onehot(mem_wr_mask))
      else $error("bad write mask");
   press_notify_a: assert property (en_q && !mem_wr_req && $rose(sw_press[0])
      |-> ##[1:200] mem_wr_req) else $error("press gave no write");
   entry_first_a: assert property (en_q && num_entry && !mem_wr_req
      |-> ##[1:6] (mem_wr_req && mem_wr_mask == 16'hffff))
      else $error("no entry word write");
   strobe_clear_a: assert property (strobe_on_s |-> ##[1:100] strobe_off_s)
      else $error("strobe not cleared");
   read_answer_a: assert property (avs_read |-> ##[0:3] !avs_waitrequest)
      else $error("read not answered");
   lamp_off_a: assert property (!(|lamp_bits) [*3] |-> !(|lamp_out))
      else $error("lamp lit while off");
endmodule // tsn_chk

// ===== tb/tsn_ctl_model.sv
/*
 Controller memory model, acks masked writes.
 Assumes the notifier's clock.
*/
`timescale 1ns/1ps
module tsn_ctl_model (
   input clk,
   input nrst,
   input mem_wr_req,
   input [15:0] mem_wr_addr,
   input [15:0] mem_wr_data,
   input [15:0] mem_wr_mask,
   input [3:0] ack_dly,
   output reg mem_wr_ack,
   output reg [15:0] last_addr,
   output reg [15:0] last_data,
   output reg [15:0] last_mask,
   output reg [15:0] seen_entry,
   output reg [31:0] wr_cnt
);
   reg [15:0] mem [0:255];
   reg [3:0] cnt_q;
   integer j;
   // Masked write after ack_dly cycles
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         mem_wr_ack <= 1'h0;
         cnt_q <= 4'h0;
         wr_cnt <= 32'h0;
         for (j = 0; j < 256; j++)
            mem[j] <= 16'h0;
      end
      else
      begin
         mem_wr_ack <= 1'h0;
         if (mem_wr_req && !mem_wr_ack && cnt_q >= ack_dly)
         begin
            mem_wr_ack <= 1'h1;
            cnt_q <= 4'h0;
            mem[mem_wr_addr[7:0]] <= (mem[mem_wr_addr[7:0]] & ~mem_wr_mask) |
               (mem_wr_data & mem_wr_mask);
            last_addr <= mem_wr_addr;
            last_data <= mem_wr_data;
            last_mask <= mem_wr_mask;
            wr_cnt <= wr_cnt + 32'h1;
            // Entry word read at strobe rise
            if (mem_wr_mask[3] && mem_wr_data[3] && !mem[mem_wr_addr[7:0]][3])
               seen_entry <= mem[mem_wr_addr[7:0] + 8'h01];
         end
         else if (mem_wr_req && !mem_wr_ack)
            cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule // tsn_ctl_model

// ===== tb/test_touch_switch_input_notifier.sv
/*
 Bench of the notifier.
 Assumes its design, model and checker.
*/
`timescale 1ns/1ps
module test_touch_switch_input_notifier;
   typedef struct packed {
      logic [1:0] ty;
      logic peer, dmem, blink;
      logic [3:0] bitp;
      logic [15:0] snap, data, mask;
   } tsn_row_t;
   logic clk = 1'h0, nrst = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
   logic screen_change = 1'h0, num_entry = 1'h0;
   logic [7:0] avs_address = 8'h0;
   logic [31:0] avs_writedata = 32'h0, rd;
   logic [15:0] sw_press = 16'h0, lamp_bits = 16'h0;
   logic [9:0] num_entry_idx = 10'h0;
   logic [3:0] ack_dly = 4'h1;
   wire [31:0] avs_readdata, wr_cnt;
   wire avs_waitrequest, irq, mem_wr_req, mem_wr_ack;
   wire [15:0] lamp_out, mem_wr_addr, mem_wr_data, mem_wr_mask;
   wire [15:0] last_addr, last_data, last_mask, seen_entry;
   integer fails = 0, comparisons = 0, wseen = 0, i, k, n2, t3;
   tsn_row_t r;
   // Type, link, area, blink, bit, snap -> data, mask
   tsn_row_t rows [0:7] = '{
      '{2'h0, 1'h0, 1'h0, 1'h0, 4'h5, 16'ha5a5, 16'h0020, 16'hffff},
      '{2'h1, 1'h0, 1'h0, 1'h0, 4'h2, 16'h1200, 16'h1204, 16'hffff},
      '{2'h2, 1'h0, 1'h0, 1'h0, 4'h0, 16'h00f0, 16'h00f1, 16'hffff},
      '{2'h3, 1'h0, 1'h0, 1'h1, 4'h7, 16'h00ff, 16'h007f, 16'hffff},
      '{2'h0, 1'h1, 1'h1, 1'h0, 4'hf, 16'h5a5a, 16'h8000, 16'hffff},
      '{2'h1, 1'h1, 1'h0, 1'h0, 4'h9, 16'hffff, 16'h0200, 16'h0200},
      '{2'h2, 1'h1, 1'h0, 1'h0, 4'hc, 16'h0000, 16'h1000, 16'h1000},
      '{2'h3, 1'h1, 1'h0, 1'h0, 4'h1, 16'hffff, 16'h0000, 16'h0002}};
   tsn_top #(.NSW(16), .SWW(4), .BLINK_HALF(8), .STROBE_HOLD(4)) DUT (
      .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .sw_press(sw_press),
      .screen_change(screen_change), .num_entry(num_entry), .num_entry_idx(num_entry_idx),
      .lamp_bits(lamp_bits), .lamp_out(lamp_out), .mem_wr_req(mem_wr_req),
      .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_mask(mem_wr_mask),
      .mem_wr_ack(mem_wr_ack));
   tsn_ctl_model u_ctl (.clk(clk), .nrst(nrst), .mem_wr_req(mem_wr_req),
      .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_mask(mem_wr_mask),
      .ack_dly(ack_dly), .mem_wr_ack(mem_wr_ack), .last_addr(last_addr),
      .last_data(last_data), .last_mask(last_mask), .seen_entry(seen_entry), .wr_cnt(wr_cnt));
   // Clock at 200 MHz
   always #2.5 clk = ~clk;
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
   begin
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   end
   endtask
   // One Avalon transfer
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      integer n;
   begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      rd = avs_readdata;
      chk("bus answer", 32'h0, {31'h0, avs_waitrequest});
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge clk);
   end
   endtask
   // Waits for one more accepted write
   task ww;
      integer n;
   begin
      n = 0;
      while (wr_cnt == wseen && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      chk("write seen", wseen + 1, wr_cnt);
      wseen = wr_cnt;
   end
   endtask
   task report_and_stop;
   begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      bus(1'h1, 8'h10, 32'h40);
      // Rows, one word per switch
      for (i = 0; i < 8; i++)
      begin
         r = rows[i];
         bus(1'h1, 8'(8'h40 + 4 * i), {8'h0, 16'(16'h20 + i), r.bitp, r.dmem, r.blink, r.ty});
         bus(1'h1, 8'(8'h80 + 4 * i), {16'h0, r.snap});
         bus(1'h1, 8'h00, {30'h0, 1'h1, r.peer});
         sw_press[i] <= 1'h1;
         ww;
         chk("row addr", 32'h20 + i, last_addr);
         chk("row data", r.data, last_data);
         chk("row mask", r.mask, last_mask);
         sw_press[i] <= 1'h0;
         if (r.ty == 2'h0)
         begin
            ww;
            chk("release data", 32'h0, last_data);
         end
      end
      $display("test rows done");
      bus(1'h1, 8'h00, 32'h2);
      sw_press[1] <= 1'h1;
      ww;
      chk("alternate again", 32'h1200, last_data);
      sw_press[1] <= 1'h0;
      bus(1'h1, 8'h08, 32'h4);
      sw_press[0] <= 1'h1;
      ww;
      screen_change <= 1'h1;
      @(posedge clk);
      screen_change <= 1'h0;
      ww;
      chk("forced off", 32'hffff0000, {last_mask, last_data});
      repeat (4) @(posedge clk);
      chk("irq set", 32'h1, irq);
      sw_press[0] <= 1'h0;
      repeat (20) @(posedge clk);
      chk("no release write", wseen, wr_cnt);
      bus(1'h1, 8'h04, 32'h4);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, irq);
      $display("test screen change done");
      ack_dly <= 4'h5;
      for (i = 0; i < 2; i++)
      begin
         num_entry_idx <= i ? 10'h000 : 10'h3e7;
         num_entry <= 1'h1;
         @(posedge clk);
         num_entry <= 1'h0;
         ww;
         chk("entry word", i ? 32'h00410000 : 32'h00410999, {last_addr, last_data});
         ww;
         chk("strobe set", 32'h00400008, {last_addr, last_data & last_mask});
         chk("entry at strobe", i ? 32'h0 : 32'h0999, seen_entry);
         ww;
         chk("strobe clear", 32'h00080000, {last_mask, last_data});
      end
      $display("test numeral done");
      lamp_bits <= 16'h000c;
      repeat (3) @(posedge clk);
      n2 = 0;
      t3 = 0;
      for (k = 0; k < 40; k++)
      begin
         @(negedge clk);
         n2 += lamp_out[2];
         t3 += lamp_out[3];
      end
      chk("steady lamp", 32'd40, n2);
      chk("blink lamp", 32'h1, (t3 > 0 && t3 < 40));
      @(posedge clk);
      lamp_bits <= 16'h0;
      repeat (3) @(posedge clk);
      chk("lamps off", 32'h0, lamp_out);
      bus(1'h0, 8'h30, 32'h0);
      chk("unmapped read", 32'h0, rd);
      bus(1'h0, 8'h08, 32'h0);
      chk("mask read", 32'h4, rd);
      $display("test lamps and bus done");
      nrst <= 1'h0;
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      wseen = 0;
      @(posedge clk);
      chk("reset outputs", 32'h0, {mem_wr_req, irq, lamp_out});
      bus(1'h0, 8'h00, 32'h0);
      chk("control reset", 32'h0, rd);
      sw_press[2] <= 1'h1;
      repeat (20) @(posedge clk);
      chk("disabled press", 32'h0, wr_cnt);
      $display("test reset done");
      report_and_stop;
   end
   // Cuts a hang short
   initial
   begin
      #150000;
      fails++;
      $display("MISMATCH watchdog expected done seen hang");
      report_and_stop;
   end
endmodule // test_touch_switch_input_notifier
bind tsn_top tsn_chk #(.NSW(NSW)) u_chk (.clk(clk), .nrst(nrst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest), .sw_press(sw_press), .num_entry(num_entry),
   .lamp_bits(lamp_bits), .lamp_out(lamp_out), .mem_wr_req(mem_wr_req),
   .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_mask(mem_wr_mask),
   .mem_wr_ack(mem_wr_ack));
